// ===== hdl/mbcd_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: AHB-Lite word registers, byte address = 4 x index
// Notes: definitions only
`ifndef MBCD_MAP_SVH
`define MBCD_MAP_SVH
`define MBCD_IDX_CTRL0 8'h06
`define MBCD_IDX_CTRL1 8'h07
`define MBCD_IDX_CLKCFG 8'h10
`define MBCD_IDX_STATUS 8'h11
`define MBCD_IDX_MASK 8'h12
`define MBCD_IDX_STATE 8'h13
`define MBCD_ADDR_CTRL0 10'h018
`define MBCD_ADDR_CTRL1 10'h01C
`define MBCD_ADDR_CLKCFG 10'h040
`define MBCD_ADDR_STATUS 10'h044
`define MBCD_ADDR_MASK 10'h048
`define MBCD_ADDR_STATE 10'h04C
`define MBCD_BIT_BIAS_EN 0
`define MBCD_BIT_SENSE_EN 1
`define MBCD_HOOK_THR_LSB 2
`define MBCD_INS_THR_LSB 4
`define MBCD_BIT_INS_POL 8
`define MBCD_BIT_HOOK_POL 9
`define MBCD_BIT_INS 0
`define MBCD_BIT_HOOK 1
`define MBCD_RST_CTRL0 16'h0000
`define MBCD_RST_CTRL1 16'h0000
`define MBCD_RST_CLKCFG 16'h0000
`define MBCD_HOOK_COUNT 4'hA
`define MBCD_TICK_NS 1000
`define MBCD_CLK_NS 10
`define MBCD_TICK_CYC (`MBCD_TICK_NS / `MBCD_CLK_NS)
`endif

// ===== hdl/mbcd_pkg.sv
// Purpose: types for the mic bias current detect block
// Assumes: none
// Notes: ratio codes name the bias level choices
package mbcd_pkg;
	typedef enum logic [2:0] {
		MBCD_R9_10, MBCD_R10_9, MBCD_R7_6, MBCD_R4_3, MBCD_R3_2
	} mbcd_ratio_e;
endpackage

// ===== hdl/mbcd_top.sv
// Purpose: mic bias control and current detect events with an AHB-Lite register slave
// Assumes: comparator inputs synchronous to hclk; one comparator pair per detector
// Notes: hysteresis comes from separate assert and release comparators
// Operation
// - bias output driven only when enabled
// - level select maps code to ratio
// - one bit enables both detectors
// - three bit insert threshold, reset zero
// - two bit hook threshold, reset zero
// - detector crossings feed interrupt logic
// - detector steady states go to pins
// - separate assert and release levels
// - hook needs ten consecutive measurements
// - insert polarity picks insertion or removal
// - hook polarity picks press or release
// - insertion detected within bounded delay
// - pin status follows the interrupt one cycle later
// - filter runs only with clocking met
// - events while stopped flagged on restore
`timescale 1ns/1ps
`include "mbcd_map.svh"
module mbcd_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Clocking criteria
	input wire logic master_clock_present,
	input wire logic loop_free_running,
	input wire logic [3:0] servo_channel_enable,
	// Analog comparators: above assert level, above release level
	input wire logic insert_above_on,
	input wire logic insert_above_off,
	input wire logic hook_above_on,
	input wire logic hook_above_off,
	// Analog controls
	output logic bias_output_enable,
	output mbcd_pkg::mbcd_ratio_e bias_ratio,
	output logic [2:0] insert_current_threshold,
	output logic [1:0] hook_current_threshold,
	output logic current_sense_enable,
	// Status and interrupt
	output logic insert_state_gpio,
	output logic hook_state_gpio,
	output logic irq
);
	import mbcd_pkg::*;

	logic [15:0] ctrl0_q;
	logic [15:0] ctrl1_q;
	logic [15:0] clkcfg_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic wr_pend_q;
	logic [9:0] wr_addr_q;
	logic [6:0] tick_cnt_q;
	logic ins_state_q;
	logic hook_state_q;
	logic [3:0] hook_cnt_q;
	logic irq_q;

	// Address phase decode
	wire addr_ok = hsel && hready && htrans[1];
	wire rd_take = addr_ok && !hwrite;
	wire wr_take = addr_ok && hwrite;
	wire [9:0] rd_addr = haddr[9:0];
	wire rd_status = rd_take && (rd_addr == `MBCD_ADDR_STATUS);
	wire sel_ctrl0 = wr_pend_q && (wr_addr_q == `MBCD_ADDR_CTRL0);
	wire sel_ctrl1 = wr_pend_q && (wr_addr_q == `MBCD_ADDR_CTRL1);
	wire sel_clk = wr_pend_q && (wr_addr_q == `MBCD_ADDR_CLKCFG);
	wire sel_mask = wr_pend_q && (wr_addr_q == `MBCD_ADDR_MASK);
	wire sys_clk_gate = clkcfg_q[0];

	// Read mux
	wire [31:0] rd_data =
		(rd_addr == `MBCD_ADDR_CTRL0) ? {16'h0000, ctrl0_q} :
		(rd_addr == `MBCD_ADDR_CTRL1) ? {16'h0000, ctrl1_q} :
		(rd_addr == `MBCD_ADDR_CLKCFG) ? {16'h0000, clkcfg_q} :
		(rd_addr == `MBCD_ADDR_STATUS) ? {30'h00000000, status_q} :
		(rd_addr == `MBCD_ADDR_MASK) ? {30'h00000000, mask_q} :
		(rd_addr == `MBCD_ADDR_STATE) ? {30'h00000000, hook_state_q, ins_state_q} :
		32'h00000000;

	// filter runs only with clock source, gate and a servo channel
	wire filt_run = (master_clock_present || loop_free_running) && sys_clk_gate
		&& (|servo_channel_enable);
	wire sense_en = ctrl0_q[`MBCD_BIT_SENSE_EN];
	// measurement tick from the system clock
	wire tick = filt_run && (tick_cnt_q == 7'(`MBCD_TICK_CYC - 1));
	// detection gated by the shared sense enable
	wire meas = tick && sense_en;

	// hysteresis, assert level to enter, release level to leave
	wire ins_next = ins_state_q ? insert_above_off : insert_above_on;
	wire hook_qual = hook_state_q ? !hook_above_off : hook_above_on;
	wire ins_chg = meas && (ins_next != ins_state_q);
	// ten consecutive qualifying measurements flip the hook state
	wire hook_chg = meas && hook_qual && (hook_cnt_q == `MBCD_HOOK_COUNT - 4'h1);
	wire ins_evt = ins_chg && (ins_next != ctrl0_q[`MBCD_BIT_INS_POL]);
	wire hook_evt = hook_chg && (hook_state_q == ctrl0_q[`MBCD_BIT_HOOK_POL]);
	wire [1:0] evt = {hook_evt, ins_evt};
	wire [1:0] status_d = (rd_status ? 2'b00 : status_q) | evt;

	wire [2:0] sel = ctrl1_q[2:0];
	wire mbcd_ratio_e ratio_d = (sel == 3'h0) ? MBCD_R9_10 :
		(sel == 3'h1) ? MBCD_R10_9 :
		(sel == 3'h2) ? MBCD_R7_6 :
		(sel == 3'h3) ? MBCD_R4_3 : MBCD_R3_2;

	// Bus slave: zero wait, OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 10'h000;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_take;
			wr_addr_q <= haddr[9:0];
			hrdata <= rd_take ? rd_data : 32'h00000000;
		end
	end

	// insert threshold and hook threshold reset to zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_q <= `MBCD_RST_CTRL0;
			ctrl1_q <= `MBCD_RST_CTRL1;
			clkcfg_q <= `MBCD_RST_CLKCFG;
			mask_q <= 2'b00;
		end else begin
			if (sel_ctrl0) begin
				ctrl0_q <= {6'h00, hwdata[9:0]};
			end
			if (sel_ctrl1) begin
				ctrl1_q <= {13'h0000, hwdata[2:0]};
			end
			if (sel_clk) begin
				clkcfg_q <= {15'h0000, hwdata[0]};
			end
			if (sel_mask) begin
				mask_q <= hwdata[1:0];
			end
		end
	end

	// comparators are levels held in analog; state catches up when ticks resume
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_q <= 7'h00;
			ins_state_q <= 1'b0;
			hook_state_q <= 1'b0;
			hook_cnt_q <= 4'h0;
		end else begin
			if (!filt_run || tick) begin
				tick_cnt_q <= 7'h00;
			end else begin
				tick_cnt_q <= tick_cnt_q + 7'h01;
			end
			if (!sense_en) begin
				ins_state_q <= 1'b0;
				hook_state_q <= 1'b0;
				hook_cnt_q <= 4'h0;
			end else if (meas) begin
				// insert path updates on every measurement
				ins_state_q <= ins_next;
				if (hook_chg) begin
					hook_state_q <= !hook_state_q;
					hook_cnt_q <= 4'h0;
				end else if (hook_qual) begin
					hook_cnt_q <= hook_cnt_q + 4'h1;
				end else begin
					hook_cnt_q <= 4'h0;
				end
			end
		end
	end

	// Status: set wins over read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 2'b00;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_q <= |(status_d & mask_q);
		end
	end

	// bias enable, pin states from the filtered state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bias_output_enable <= 1'b0;
			bias_ratio <= MBCD_R9_10;
			insert_current_threshold <= 3'h0;
			hook_current_threshold <= 2'h0;
			current_sense_enable <= 1'b0;
			insert_state_gpio <= 1'b0;
			hook_state_gpio <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			bias_output_enable <= ctrl0_q[`MBCD_BIT_BIAS_EN];
			bias_ratio <= ratio_d;
			insert_current_threshold <= ctrl0_q[`MBCD_INS_THR_LSB +: 3];
			hook_current_threshold <= ctrl0_q[`MBCD_HOOK_THR_LSB +: 2];
			current_sense_enable <= sense_en;
			insert_state_gpio <= ins_state_q;
			hook_state_gpio <= hook_state_q;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign irq = irq_q;
endmodule // mbcd_top

// ===== tb/mbcd_mic.sv
// Purpose: accessory load model driving both comparator pairs
// Assumes: load in uA; release level 20 uA below assert level
// Notes: levels follow the threshold codes
`timescale 1ns/1ps
module mbcd_mic (
	// Load and threshold codes
	input wire logic [11:0] load_ua,
	input wire logic [2:0] insert_current_threshold,
	input wire logic [1:0] hook_current_threshold,
	// Comparators
	output logic insert_above_on,
	output logic insert_above_off,
	output logic hook_above_on,
	output logic hook_above_off
);
	wire [11:0] ins_lvl = 12'h046 + 12'h0BE * insert_current_threshold;
	wire [11:0] hook_lvl = 12'h208 + 12'h168 * hook_current_threshold;
	assign insert_above_on = load_ua >= ins_lvl;
	assign insert_above_off = load_ua >= ins_lvl - 12'h014;
	assign hook_above_on = load_ua >= hook_lvl;
	assign hook_above_off = load_ua >= hook_lvl - 12'h014;
endmodule // mbcd_mic

// ===== tb/mbcd_asserts.sv
// Purpose: port checks for mbcd_top
// Assumes: one clock domain
// Notes: bind at foot
`timescale 1ns/1ps
module mbcd_asserts (
	// Bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	// Clocking and comparators
	input wire logic master_clock_present,
	input wire logic loop_free_running,
	input wire logic [3:0] servo_channel_enable,
	input wire logic insert_above_on,
	input wire logic insert_above_off,
	input wire logic hook_above_on,
	// Outputs
	input wire mbcd_pkg::mbcd_ratio_e bias_ratio,
	input wire logic bias_output_enable,
	input wire logic [2:0] insert_current_threshold,
	input wire logic [1:0] hook_current_threshold,
	input wire logic current_sense_enable,
	input wire logic insert_state_gpio,
	input wire logic hook_state_gpio
);
	import mbcd_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [11:0] hook_n_q;
	wire wr = hsel && hready && htrans[1] && hwrite;
	wire wr0 = wr && haddr == 32'h18;
	wire wr1 = wr && haddr == 32'h1C;
	wire run = (master_clock_present || loop_free_running) && |servo_channel_enable;
	wire [6:0] ctl = {insert_current_threshold, hook_current_threshold, current_sense_enable,
		bias_output_enable};
	// Cycles the hook comparator has stood above its level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hook_n_q <= 12'h000;
		else hook_n_q <= hook_above_on ? hook_n_q + {11'h000, hook_n_q != 12'hFFF} : 12'h000;
	end
	property p_ctl; $changed(ctl) |-> $past(wr0, 2) || $past(wr0, 3) || $past(wr0, 4); endproperty
	a_ctl: assert property (p_ctl) else $error("control moved without write");
	property p_rat; $changed(bias_ratio) |-> $past(wr1, 2) || $past(wr1, 3) || $past(wr1, 4); endproperty
	a_rat: assert property (p_rat) else $error("ratio moved without write");
	property p_off; !current_sense_enable [*3] |-> !insert_state_gpio && !hook_state_gpio; endproperty
	a_off: assert property (p_off) else $error("state while sense off");
	property p_en; $rose(insert_state_gpio) || $rose(hook_state_gpio) |-> current_sense_enable; endproperty
	a_en: assert property (p_en) else $error("event with sense off");
	property p_hook; $rose(hook_state_gpio) |-> hook_n_q >= 12'h384; endproperty
	a_hook: assert property (p_hook) else $error("hook press too early");
	property p_stall; (!run && current_sense_enable) [*5] |-> $stable({insert_state_gpio, hook_state_gpio}); endproperty
	a_stall: assert property (p_stall) else $error("state moved while stopped");
	property p_rise; $rose(insert_state_gpio) |-> $past(insert_above_on, 2) || $past(insert_above_on, 3); endproperty
	a_rise: assert property (p_rise) else $error("insert below assert level");
	property p_fall; $fell(insert_state_gpio) && current_sense_enable |-> !$past(insert_above_off, 2) || !$past(insert_above_off, 3); endproperty
	a_fall: assert property (p_fall) else $error("removal above release level");
endmodule // mbcd_asserts
bind mbcd_top mbcd_asserts mbcd_asserts_inst (.*);

// ===== tb/tb_top.sv
// Purpose: self-checking bench for mbcd_top
// Assumes: tick every 100 cycles
// Notes: load_ua drives the accessory model
`timescale 1ns/1ps
module tb_top;
	import mbcd_pkg::*;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp, irq;
	logic master_clock_present = 1'h1, loop_free_running = 1'h0, current_sense_enable;
	logic insert_above_on, insert_above_off, hook_above_on, hook_above_off, bias_output_enable;
	logic insert_state_gpio, hook_state_gpio;
	logic [1:0] htrans = 2'h0, hook_current_threshold;
	logic [2:0] hsize = 3'h2, insert_current_threshold;
	logic [3:0] servo_channel_enable = 4'h1;
	logic [11:0] load_ua = 12'h000;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	mbcd_ratio_e bias_ratio;
	int seed = 32'hD737, n_fail = 0, checks = 0, cyc = 0, mdl[int];
	int msk[int] = '{32'h18: 32'h3FF, 32'h1C: 32'h7, 32'h20: 32'h0, 32'h40: 32'h1, 32'h48: 32'h3};
	mbcd_top mbcd_top_inst (.*);
	mbcd_mic mbcd_mic_inst (.*);
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out;
		end
	end
	task automatic chk(input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		xfer(1'h1, a, d);
		mdl[a] = d;
	endtask
	task automatic rd(input logic [31:0] a, e);
		xfer(1'h0, a, 32'h0);
		chk(q, e);
		chk({hreadyout, hresp}, 2'h2);
	endtask
	// Set the load, wait, then compare pins, irq and read-clear status
	task automatic ev(input logic [11:0] ld, input int n, input logic [1:0] st, g);
		load_ua <= ld;
		repeat (n) @(posedge hclk);
		chk({hook_state_gpio, insert_state_gpio}, g);
		chk(irq, |(st & mdl[32'h48]));
		rd(32'h44, st);
		rd(32'h4C, g);
		$display("step done at %0t", $time);
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		foreach (msk[a]) begin
			rd(a, 0);
			wr(a, $random(seed));
			rd(a, mdl[a] & msk[a]);
		end
		chk({insert_current_threshold, hook_current_threshold, current_sense_enable,
			bias_output_enable}, mdl[32'h18] & 32'h7F);
		for (int i = 0; i < 8; i++) begin
			wr(32'h1C, i);
			repeat (2) @(posedge hclk);
			chk(bias_ratio, i > 4 ? 4 : i);
		end
		$display("register step done");
		wr(32'h40, 1);
		wr(32'h48, 3);
		wr(32'h18, 32'h12);
		ev(400, 150, 1, 1);
		ev(600, 500, 0, 1);
		ev(400, 150, 0, 1);
		ev(600, 850, 0, 1);
		ev(600, 250, 2, 3);
		// polarity changed only after the state has settled
		wr(32'h18, 32'h312);
		ev(400, 1100, 2, 1);
		ev(0, 150, 1, 0);
		master_clock_present <= 1'h0;
		wr(32'h18, 32'h12);
		ev(400, 500, 0, 0);
		loop_free_running <= 1'h1;
		wr(32'h48, 2);
		ev(400, 150, 1, 1);
		servo_channel_enable <= 4'h0;
		ev(0, 500, 0, 1);
		servo_channel_enable <= 4'h8;
		wr(32'h40, 0);
		ev(0, 500, 0, 1);
		wr(32'h40, 1);
		ev(0, 150, 0, 0);
		wr(32'h18, 32'h10);
		ev(600, 1100, 0, 0);
		close_out;
	end
endmodule // tb_top
